// ===== rtl/lbr_regs.svh
// register map, field positions, reset values and ramp timing constants
// Notes on behaviour
// - each 5-bit code maps to a fixed exponential current table, 0 off, 31 full.
// - a rewritten code moves the applied current one code per step, the first step at once.
// - ramp field read as {bit 3, bit 4}, 00/01/10/11 selects 51 us, 13 ms, 26 ms, 52 ms per step.
// - a transition lasts (absolute code difference minus one) times the step time.
// - the shared pin is an active-low reset until pin control bit 0 is set.
// - in I/O mode with bit 1 clear, bit 2 reads back the pin level.
// - with the shared level bit set, the primary code drives both sinks.
// - brightness registers at 0xa0 and 0xb0 use only their five low bits.
// - ramp bits sit at bits 3 and 4 of the configuration register, both sinks.
`ifndef LBR_REGS_SVH
`define LBR_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LBR_OFS_CONFIG 8'h10
`define LBR_OFS_PIN_CTRL 8'h80
`define LBR_OFS_PRIMARY 8'ha0
`define LBR_OFS_SECONDARY 8'hb0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LBR_CFG_EN_PRIMARY 0
`define LBR_CFG_EN_SECONDARY 1
`define LBR_CFG_SHARED 2
`define LBR_CFG_RAMP_LOW 3
`define LBR_CFG_RAMP_HIGH 4
`define LBR_CFG_FEEDBACK 5
`define LBR_PIN_ENABLE 0
`define LBR_PIN_DIR 1
`define LBR_PIN_DATA 2

// ----------------------------------------------------------------
// reset values and read fill
// ----------------------------------------------------------------
`define LBR_CFG_RESET 6'h00
`define LBR_PIN_RESET 3'h0
`define LBR_CODE_RESET 5'h00
`define LBR_CFG_FILL 2'h3
`define LBR_CODE_FILL 3'h7
`define LBR_PIN_FILL 5'h1f
`define LBR_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// ramp step times, clock rate and derived cycle counts
// ----------------------------------------------------------------
`define LBR_CLK_KHZ 50000
`define LBR_STEP0_US 51
`define LBR_STEP1_MS 13
`define LBR_STEP2_MS 26
`define LBR_STEP3_MS 52
`define LBR_STEP0_CYC (`LBR_STEP0_US * `LBR_CLK_KHZ / 1000)
`define LBR_STEP1_CYC (`LBR_STEP1_MS * `LBR_CLK_KHZ)
`define LBR_STEP2_CYC (`LBR_STEP2_MS * `LBR_CLK_KHZ)
`define LBR_STEP3_CYC (`LBR_STEP3_MS * `LBR_CLK_KHZ)

`endif

// ===== rtl/lbr_pkg.sv
// shared types of the led brightness ramp block
package lbr_pkg;

  typedef logic [4:0] lbr_code_t;
  typedef logic [16:0] lbr_level_t;  // thousandths of a percent of full scale

  // serial slave states, one-hot
  typedef enum logic [8:0] {
    LBR_ST_IDLE = 9'h001,
    LBR_ST_ADDR = 9'h002,
    LBR_ST_AACK = 9'h004,
    LBR_ST_REG = 9'h008,
    LBR_ST_RACK = 9'h010,
    LBR_ST_WDAT = 9'h020,
    LBR_ST_WACK = 9'h040,
    LBR_ST_RDAT = 9'h080,
    LBR_ST_MACK = 9'h100
  } lbr_i2c_state_t;

endpackage

// ===== rtl/lbr_i2c_slave.sv
// i2c register slave: one pointer byte, then data written or read
module lbr_i2c_slave #(
  parameter logic [6:0] SLAVE_ID = 7'h2a  // arbitrary value
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // register side
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  input wire logic [7:0] i_rdata
);

  lbr_pkg::lbr_i2c_state_t state_reg;
  logic scl_reg;
  logic sda_reg;
  logic rw_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;

  // bus events, sampled against the previous pin levels
  wire start_ev = scl_reg & i_scl & sda_reg & ~i_sda;
  wire stop_ev = scl_reg & i_scl & ~sda_reg & i_sda;
  wire rise_ev = ~scl_reg & i_scl;
  wire fall_ev = scl_reg & ~i_scl;
  wire byte_done = (cnt_reg == 4'h8);
  wire id_match = (shift_reg[7:1] == SLAVE_ID);

  assign o_sda_o = 1'b0;  // open drain: only ever pulls low

  // pin history
  always_ff @(posedge i_sys_clk)
  begin
    scl_reg <= i_nrst ? i_scl : 1'b1;
    sda_reg <= i_nrst ? i_sda : 1'b1;
  end

  // protocol engine; data moves on falling scl so it is stable while high
  always_ff @(posedge i_sys_clk)
  begin
    o_wr <= 1'b0;
    if (!i_nrst)
    begin
      state_reg <= lbr_pkg::LBR_ST_IDLE;
      o_sda_oe <= 1'b0;
      rw_reg <= 1'b0;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      o_addr <= 8'h00;
      o_wdata <= 8'h00;
    end
    else if (start_ev)
    begin
      state_reg <= lbr_pkg::LBR_ST_ADDR;
      cnt_reg <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_reg <= lbr_pkg::LBR_ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (rise_ev)
    begin
      unique case (state_reg)
        lbr_pkg::LBR_ST_ADDR, lbr_pkg::LBR_ST_REG, lbr_pkg::LBR_ST_WDAT:
        begin
          shift_reg <= {shift_reg[6:0], i_sda};
          cnt_reg <= cnt_reg + 4'h1;
        end
        lbr_pkg::LBR_ST_RDAT:
          cnt_reg <= cnt_reg + 4'h1;
        lbr_pkg::LBR_ST_MACK:
          if (i_sda)
            state_reg <= lbr_pkg::LBR_ST_IDLE;  // host said no more
        default:
          ;
      endcase
    end
    else if (fall_ev)
    begin
      unique case (state_reg)
        lbr_pkg::LBR_ST_ADDR:
          if (byte_done)
          begin
            state_reg <= id_match ? lbr_pkg::LBR_ST_AACK : lbr_pkg::LBR_ST_IDLE;
            o_sda_oe <= id_match;
            rw_reg <= shift_reg[0];
          end
        lbr_pkg::LBR_ST_REG:
          if (byte_done)
          begin
            state_reg <= lbr_pkg::LBR_ST_RACK;
            o_addr <= shift_reg;
            o_sda_oe <= 1'b1;
          end
        lbr_pkg::LBR_ST_WDAT:
          if (byte_done)
          begin
            state_reg <= lbr_pkg::LBR_ST_WACK;
            o_wdata <= shift_reg;
            o_wr <= 1'b1;
            o_sda_oe <= 1'b1;
          end
        lbr_pkg::LBR_ST_AACK, lbr_pkg::LBR_ST_MACK:
        begin
          cnt_reg <= 4'h0;
          if (rw_reg)
          begin
            state_reg <= lbr_pkg::LBR_ST_RDAT;
            shift_reg <= i_rdata;
            o_sda_oe <= ~i_rdata[7];
          end
          else
          begin
            state_reg <= lbr_pkg::LBR_ST_REG;
            o_sda_oe <= 1'b0;
          end
        end
        lbr_pkg::LBR_ST_RACK, lbr_pkg::LBR_ST_WACK:
        begin
          state_reg <= lbr_pkg::LBR_ST_WDAT;
          cnt_reg <= 4'h0;
          o_sda_oe <= 1'b0;
        end
        lbr_pkg::LBR_ST_RDAT:
          if (byte_done)
          begin
            state_reg <= lbr_pkg::LBR_ST_MACK;
            o_sda_oe <= 1'b0;
          end
          else
          begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            o_sda_oe <= ~shift_reg[6];
          end
        default:
          ;
      endcase
    end
  end

endmodule

// ===== rtl/lbr_top.sv
// led brightness ramp with register file and shared reset/io pin
`include "lbr_regs.svh"

module lbr_top #(
  parameter logic [6:0] SLAVE_ID = 7'h2a,  // arbitrary value
  parameter int STEP0_CYC = `LBR_STEP0_CYC,
  parameter int STEP1_CYC = `LBR_STEP1_CYC,
  parameter int STEP2_CYC = `LBR_STEP2_CYC,
  parameter int STEP3_CYC = `LBR_STEP3_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // serial register port
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // shared reset / io pin
  input wire logic i_pin,
  output logic o_pin_o,
  output logic o_pin_oe,
  // sink control
  output logic o_primary_en,
  output logic o_secondary_en,
  output logic o_feedback_mode,
  output logic [4:0] o_primary_code,
  output logic [4:0] o_secondary_code,
  output logic [16:0] o_primary_level,
  output logic [16:0] o_secondary_level
);

  // ----------------------------------------------------------------
  // current table
  // ----------------------------------------------------------------

  // exponential table in thousandths of a percent of full scale
  function automatic lbr_pkg::lbr_level_t level_of(lbr_pkg::lbr_code_t c);
    lbr_pkg::lbr_level_t v;
    v = 17'h00000;
    unique case (c)
      5'h00: v = 17'd0;
      5'h01: v = 17'd125;
      5'h02: v = 17'd625;
      5'h03: v = 17'd1000;
      5'h04: v = 17'd1125;
      5'h05: v = 17'd1313;
      5'h06: v = 17'd1688;
      5'h07: v = 17'd2063;
      5'h08: v = 17'd2438;
      5'h09: v = 17'd2813;
      5'h0a: v = 17'd3125;
      5'h0b: v = 17'd3750;
      5'h0c: v = 17'd4375;
      5'h0d: v = 17'd5250;
      5'h0e: v = 17'd6250;
      5'h0f: v = 17'd7500;
      5'h10: v = 17'd8750;
      5'h11: v = 17'd10000;
      5'h12: v = 17'd12500;
      5'h13: v = 17'd15000;
      5'h14: v = 17'd16875;
      5'h15: v = 17'd18750;
      5'h16: v = 17'd22500;
      5'h17: v = 17'd26250;
      5'h18: v = 17'd31250;
      5'h19: v = 17'd37500;
      5'h1a: v = 17'd43750;
      5'h1b: v = 17'd52500;
      5'h1c: v = 17'd61250;
      5'h1d: v = 17'd70000;
      5'h1e: v = 17'd87500;
      5'h1f: v = 17'd100000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------

  logic [5:0] cfg_reg;
  logic [2:0] pin_reg;
  lbr_pkg::lbr_code_t primary_reg;
  lbr_pkg::lbr_code_t secondary_reg;
  wire [7:0] bus_addr;
  wire [7:0] bus_wdata;
  wire bus_wr;
  wire [7:0] bus_rdata;

  // pin held low in reset mode clears the device like the main reset
  wire pin_is_io = pin_reg[`LBR_PIN_ENABLE];
  wire dev_nrst = i_nrst & (pin_is_io | i_pin);

  lbr_i2c_slave #(
    .SLAVE_ID(SLAVE_ID)
  ) u_i2c (
    .i_sys_clk(i_sys_clk),
    .i_nrst(dev_nrst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .o_wr(bus_wr),
    .i_rdata(bus_rdata)
  );

  // address decode
  wire sel_cfg = (bus_addr == `LBR_OFS_CONFIG);
  wire sel_pin = (bus_addr == `LBR_OFS_PIN_CTRL);
  wire sel_pri = (bus_addr == `LBR_OFS_PRIMARY);
  wire sel_sec = (bus_addr == `LBR_OFS_SECONDARY);

  // register writes; upper brightness bits are dropped
  always_ff @(posedge i_sys_clk)
  begin
    if (!dev_nrst)
    begin
      cfg_reg <= `LBR_CFG_RESET;
      pin_reg <= `LBR_PIN_RESET;
      primary_reg <= `LBR_CODE_RESET;
      secondary_reg <= `LBR_CODE_RESET;
    end
    else if (bus_wr)
    begin
      if (sel_cfg)
        cfg_reg <= bus_wdata[5:0];
      if (sel_pin)
        pin_reg <= bus_wdata[2:0];
      if (sel_pri)
        primary_reg <= bus_wdata[4:0];
      if (sel_sec)
        secondary_reg <= bus_wdata[4:0];
    end
  end

  // pin data bit shows the live pin level while it is an input
  wire pin_dir_out = pin_reg[`LBR_PIN_DIR];
  wire pin_rd_bit = pin_dir_out ? pin_reg[`LBR_PIN_DATA] : i_pin;
  wire [7:0] rd_cfg = {`LBR_CFG_FILL, cfg_reg};
  wire [7:0] rd_pin = {`LBR_PIN_FILL, pin_rd_bit, pin_reg[1:0]};
  wire [7:0] rd_pri = {`LBR_CODE_FILL, primary_reg};
  wire [7:0] rd_sec = {`LBR_CODE_FILL, secondary_reg};
  assign bus_rdata = sel_cfg ? rd_cfg :
                     sel_pin ? rd_pin :
                     sel_pri ? rd_pri :
                     sel_sec ? rd_sec : `LBR_UNMAPPED_READ;

  // open drain: only the low level is driven, a one floats the pin
  assign o_pin_o = 1'b0;
  assign o_pin_oe = pin_is_io & pin_dir_out & ~pin_reg[`LBR_PIN_DATA];

  // ----------------------------------------------------------------
  // ramp engines
  // ----------------------------------------------------------------

  // ramp select taken as low bit first, then high bit
  wire [1:0] ramp_sel = {cfg_reg[`LBR_CFG_RAMP_LOW],
                         cfg_reg[`LBR_CFG_RAMP_HIGH]};
  wire [21:0] step_cyc = (ramp_sel == 2'h0) ? 22'(STEP0_CYC) :
                         (ramp_sel == 2'h1) ? 22'(STEP1_CYC) :
                         (ramp_sel == 2'h2) ? 22'(STEP2_CYC) :
                         22'(STEP3_CYC);

  // shared mode makes the secondary sink follow the primary code
  wire shared = cfg_reg[`LBR_CFG_SHARED];
  lbr_pkg::lbr_code_t target [2];
  assign target[0] = primary_reg;
  assign target[1] = shared ? primary_reg : secondary_reg;

  lbr_pkg::lbr_code_t applied [2];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ramp
      logic [4:0] code_reg;
      logic [21:0] timer_reg;
      wire differ = (code_reg != target[ch]);
      wire step_now = differ & (timer_reg == 22'h000000);
      wire [4:0] code_step = (code_reg < target[ch]) ? code_reg + 5'h01 :
                                                       code_reg - 5'h01;
      // first step lands at once, later ones wait a full interval, so a
      // change of n codes takes n-1 intervals
      always_ff @(posedge i_sys_clk)
      begin
        if (!dev_nrst)
        begin
          code_reg <= `LBR_CODE_RESET;
          timer_reg <= 22'h000000;
        end
        else if (!differ)
          timer_reg <= 22'h000000;
        else if (step_now)
        begin
          code_reg <= code_step;
          timer_reg <= step_cyc - 22'h000001;
        end
        else
          timer_reg <= timer_reg - 22'h000001;
      end
      assign applied[ch] = code_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // sink outputs
  // ----------------------------------------------------------------

  // feedback mode turns the secondary pin into a regulator input
  always_ff @(posedge i_sys_clk)
  begin
    if (!dev_nrst)
    begin
      o_primary_en <= 1'b0;
      o_secondary_en <= 1'b0;
      o_feedback_mode <= 1'b0;
      o_primary_code <= `LBR_CODE_RESET;
      o_secondary_code <= `LBR_CODE_RESET;
      o_primary_level <= 17'h00000;
      o_secondary_level <= 17'h00000;
    end
    else
    begin
      o_feedback_mode <= cfg_reg[`LBR_CFG_FEEDBACK];
      o_primary_en <= cfg_reg[`LBR_CFG_EN_PRIMARY];
      o_secondary_en <= ~cfg_reg[`LBR_CFG_FEEDBACK] &
                        (shared ? cfg_reg[`LBR_CFG_EN_PRIMARY] :
                                  cfg_reg[`LBR_CFG_EN_SECONDARY]);
      o_primary_code <= applied[0];
      o_secondary_code <= applied[1];
      o_primary_level <= level_of(applied[0]);
      o_secondary_level <= level_of(applied[1]);
    end
  end

endmodule

// ===== testbench/lbr_top_sva.sv
// port assertions for the led brightness ramp block
module lbr_top_sva (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // pins
  input wire logic i_scl,
  input wire logic i_pin,
  input wire logic o_sda_oe,
  input wire logic o_pin_o,
  // sink control
  input wire logic [4:0] o_primary_code,
  input wire logic [4:0] o_secondary_code,
  input wire logic [16:0] o_primary_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a low pin may be the shared reset, which clears codes at once
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst || !i_pin);

  sequence pri_moved;
    $changed(o_primary_code);
  endsequence
  sequence sec_moved;
    $changed(o_secondary_code);
  endsequence

  ack_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while serial clock high");
  pin_drive_low_a: assert property (o_pin_o == 1'b0)
    else $error("shared pin driven high");
  step_one_pri_a: assert property (pri_moved |->
    (o_primary_code - $past(o_primary_code) == 5'h01) ||
    ($past(o_primary_code) - o_primary_code == 5'h01))
    else $error("primary code jumped by more than one");
  step_one_sec_a: assert property (sec_moved |->
    (o_secondary_code - $past(o_secondary_code) == 5'h01) ||
    ($past(o_secondary_code) - o_secondary_code == 5'h01))
    else $error("secondary code jumped by more than one");
  step_gap_pri_a: assert property (pri_moved |=>
    $stable(o_primary_code)[*3])
    else $error("primary steps closer than the shortest step");
  step_gap_sec_a: assert property (sec_moved |=>
    $stable(o_secondary_code)[*3])
    else $error("secondary steps closer than the shortest step");
  level_off_a: assert property ((o_primary_code == 5'h00)[*2] |->
    o_primary_level == 17'h00000)
    else $error("code zero does not give zero current");
  level_full_a: assert property ((o_primary_code == 5'h1f)[*2] |->
    o_primary_level == 17'd100000)
    else $error("full code does not give full current");
endmodule

bind lbr_top lbr_top_sva i_lbr_top_sva (.i_sys_clk, .i_nrst, .i_scl,
  .i_pin, .o_sda_oe, .o_pin_o, .o_primary_code, .o_secondary_code,
  .o_primary_level);

// ===== testbench/lbr_i2c_host.sv
// serial host model that writes and reads the block's registers
module lbr_i2c_host #(
  parameter logic [6:0] ID = 7'h2a  // arbitrary value
) (
  // clock
  input wire logic i_sys_clk,
  // serial lines, data is open drain
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: clock high, data released to the pull-up
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // data moves only while the clock line is low
  task automatic bit_tx(input logic b, output logic r);
    o_sda_oe <= !b;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    r = i_sda;
    o_scl <= 1'b0;
    hold(2);
  endtask

  // the ninth bit is released: ack from device, nack from host on reads
  task automatic byte_tx(input logic [7:0] d, output logic [7:0] r,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_tx(d[i], r[i]);
    bit_tx(1'b1, a);
    ack = !a;
  endtask

  task automatic start();
    o_sda_oe <= 1'b0;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    o_sda_oe <= 1'b1;
    hold(4);
    o_scl <= 1'b0;
    hold(2);
  endtask

  task automatic stop();
    o_sda_oe <= 1'b1;
    hold(4);
    o_scl <= 1'b1;
    hold(4);
    o_sda_oe <= 1'b0;
    hold(4);
  endtask

  task automatic write_reg(input logic [6:0] id, input logic [7:0] a,
    input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    byte_tx({id, 1'b0}, r, k0);
    byte_tx(a, r, k1);
    byte_tx(d, r, k2);
    stop();
    ok = k0 && k1 && k2;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start();
    byte_tx({ID, 1'b0}, r, k0);
    byte_tx(a, r, k1);
    start();
    byte_tx({ID, 1'b1}, r, k2);
    byte_tx(8'hff, d, k3);
    stop();
    ok = k0 && k1 && k2;
  endtask
endmodule

// ===== testbench/lbr_top_tb_top.sv
// self-checking bench for the led brightness ramp block
module lbr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ID = 7'h2a;
  localparam int STEP [4] = '{4, 8, 12, 16};
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic pin_ext = 1'b1;
  logic scl, host_oe, sda_oe, pin_oe, ok;
  logic pri_en, sec_en, fb_mode, sda_o, pin_o;
  logic [4:0] pri_code, sec_code, prev_code;
  logic [16:0] pri_level, sec_level;
  logic [7:0] rd;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int t_first, t_last;
  // both lines have pull-ups; any driver pulls low
  wire logic sda = !(host_oe || sda_oe);
  wire logic pin = !pin_oe && pin_ext;

  lbr_top #(.SLAVE_ID(ID), .STEP0_CYC(4), .STEP1_CYC(8), .STEP2_CYC(12),
    .STEP3_CYC(16)) i_lbr_top (.i_sys_clk, .i_nrst, .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_pin(pin),
    .o_pin_o(pin_o), .o_pin_oe(pin_oe), .o_primary_en(pri_en),
    .o_secondary_en(sec_en), .o_feedback_mode(fb_mode),
    .o_primary_code(pri_code), .o_secondary_code(sec_code),
    .o_primary_level(pri_level), .o_secondary_level(sec_level));
  lbr_i2c_host #(.ID(ID)) i_lbr_i2c_host (.i_sys_clk, .i_sda(sda),
    .o_scl(scl), .o_sda_oe(host_oe));

  initial
  begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // step times and hang guard; ceiling well above the expected run
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    prev_code <= pri_code;
    if (pri_code !== prev_code)
    begin
      if (t_first < 0)
        t_first <= cyc;
      t_last <= cyc;
    end
    if (cyc == 40000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_lbr_i2c_host.write_reg(ID, a, d, ok);
    chk(ok, 1'b1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_lbr_i2c_host.read_reg(a, rd, ok);
    chk({ok, rd}, {1'b1, e});
  endtask

  // rate field is written low bit at bit 4, so the selector reads {b3,b4}
  task automatic ramp(input logic [1:0] r, input logic [4:0] c, input int n,
    input logic [16:0] lvl);
    wr(8'h10, {3'h0, r[0], r[1], 3'h1});
    t_first = -1;
    wr(8'ha0, {3'h7, c});
    repeat (600) if (pri_code !== c) @(posedge i_sys_clk);
    repeat (2) @(posedge i_sys_clk);
    chk(pri_code, c);
    chk(17'(t_last - t_first), 17'((n - 1) * STEP[r]));
    chk(pri_level, lvl);
    rdc(8'ha0, {3'h7, c});
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    rdc(8'h10, 8'hc0);
    rdc(8'ha0, 8'he0);
    rdc(8'h20, 8'h00);
    ramp(2'h0, 5'h07, 7, 17'd2063);
    ramp(2'h1, 5'h02, 5, 17'd625);
    ramp(2'h2, 5'h1f, 29, 17'd100000);
    ramp(2'h3, 5'h10, 15, 17'd8750);
    i_lbr_i2c_host.write_reg(7'h15, 8'ha0, 8'h00, ok);
    chk(ok, 1'b0);
    wr(8'hb0, 8'h03);
    wr(8'h10, 8'h05);
    wr(8'hb0, 8'h01);
    repeat (600) if (sec_code !== 5'h10) @(posedge i_sys_clk);
    repeat (40) @(posedge i_sys_clk);
    chk(sec_code, 5'h10);
    chk(sec_level, 17'd8750);
    chk({pri_en, sec_en, fb_mode}, 3'h6);
    wr(8'h10, 8'h25);
    chk({pri_en, sec_en, fb_mode}, 3'h5);
    pin_ext <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    pin_ext <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    chk(pri_code, 5'h00);
    chk({pri_en, sec_en, fb_mode, sda_o, pin_o}, 5'h00);
    rdc(8'h10, 8'hc0);
    wr(8'h80, 8'h01);
    pin_ext <= 1'b0;
    rdc(8'h80, 8'hf9);
    pin_ext <= 1'b1;
    rdc(8'h80, 8'hfd);
    wr(8'h80, 8'h03);
    chk(pin_oe, 1'b1);
    wr(8'h80, 8'h07);
    chk(pin_oe, 1'b0);
    report_and_stop();
  end
endmodule
